//--- shared/tsr_regs.vh
// Register map, field positions and reset values of the sync router
`ifndef TSR_REGS_VH
`define TSR_REGS_VH

// Word offsets (byte addresses)
`define TSR_A_CTRL 8'h00
`define TSR_A_SRC 8'h04
`define TSR_A_TIMER 8'h08
`define TSR_A_COUNT 8'h0c
`define TSR_A_PREARM 8'h10
`define TSR_A_OUTCFG 8'h14
`define TSR_A_STATUS 8'h18

// Control bits, write-one pulses
`define TSR_CTRL_INIT 0
`define TSR_CTRL_IMM 1
`define TSR_CTRL_ABORT 2

// Source register fields
`define TSR_SRC_TRIG_LSB 0
`define TSR_SRC_ARM_LSB 8
`define TSR_SRC_REF_LSB 16
`define TSR_SRC_MASK 32'h0007_0f0f
`define TSR_SRC_RST 32'h0000_0000

// Source codes shared by trigger and arm selection
`define TSR_SEL_TIMER 4'h0
`define TSR_SEL_HOLD 4'h1
`define TSR_SEL_EXT1 4'h2
`define TSR_SEL_EXT2 4'h3
`define TSR_SEL_ECL0 4'h4
`define TSR_SEL_TTL0 4'h8

// Reference source codes
`define TSR_REF_INT 3'h0
`define TSR_REF_CLK10 3'h1
`define TSR_REF_ECL0 3'h2
`define TSR_REF_EXT2 3'h4

// Edges after reset before synchronised pin edges are trusted
`define TSR_SETTLE_CNT 2'h3

// Timer period, in reference edges
`define TSR_TIMER_MASK 32'h0000_ffff
`define TSR_TIMER_RST 32'h0000_0001

// Count register: readings per arm, arm count
`define TSR_CNT_TRIG_LSB 0
`define TSR_CNT_ARM_LSB 16
`define TSR_CNT_MASK 32'h00ff_ffff
`define TSR_CNT_RST 32'h0001_0001

`define TSR_PRE_MASK 32'h0000_ffff
`define TSR_PRE_RST 32'h0000_0000

// Output configuration fields
`define TSR_OUT_BNC_FEED 0
`define TSR_OUT_ECL_FEED 2
`define TSR_OUT_BNC_EN 8
`define TSR_OUT_ECL_EN 9
`define TSR_OUT_TTL_EN 16
`define TSR_OUT_MASK 32'h00ff_073f
`define TSR_OUT_RST 32'h0000_0000

// Feed codes of the front output and the ECL lines
`define TSR_FEED_TRIG 2'h0
`define TSR_FEED_REF 2'h1
`define TSR_FEED_AUX 2'h2

// Status fields
`define TSR_ST_ACTIVE 0
`define TSR_ST_WAIT 1
`define TSR_ST_PREHIT 2
`define TSR_ST_LEFT_LSB 16

`endif

//--- verilog/tsr_sync2.v
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module tsr_sync2 #(
  parameter W = 13
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Levels
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

//--- verilog/tsr_seq.v
// Trigger sequencer: pre-arm, arm, post-arm readings and convert pulses
`timescale 1ns/1ps
module tsr_seq #(
  parameter CW = 16,
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Commands and events
  input wire start_i,
  input wire abort_i,
  input wire imm_i,
  input wire arm_evt_i,
  input wire trig_evt_i,
  // Counts
  input wire [CW-1:0] prearm_i,
  input wire [CW-1:0] count_i,
  input wire [AW-1:0] arms_i,
  // State
  output reg convert_o,
  output reg active_o,
  output reg wait_o,
  output reg prehit_o,
  output reg [CW-1:0] left_o
);

  localparam S_IDLE = 2'd0;
  localparam S_PRE = 2'd1;
  localparam S_POST = 2'd2;

  reg [1:0] st_q;
  reg [CW-1:0] pre_q;
  reg [AW-1:0] arms_q;
  wire pre_on = (prearm_i != {CW{1'b0}});
  wire [CW-1:0] post_n = (count_i > prearm_i) ?
    count_i - prearm_i : {{(CW-1){1'b0}}, 1'b1};

  // One burst per arm; ready only after all arms and readings, or at once on an abort
  always @(posedge clk_i) begin
    convert_o <= 1'b0;
    if (rst_i) begin
      st_q <= S_IDLE;
      pre_q <= {CW{1'b0}};
      arms_q <= {AW{1'b0}};
      active_o <= 1'b0;
      wait_o <= 1'b0;
      prehit_o <= 1'b0;
      left_o <= {CW{1'b0}};
    end else if (abort_i) begin
      st_q <= S_IDLE;
      active_o <= 1'b0;
      wait_o <= 1'b0;
      prehit_o <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (start_i) begin
            st_q <= S_PRE;
            pre_q <= {CW{1'b0}};
            arms_q <= (arms_i == {AW{1'b0}}) ? {{(AW-1){1'b0}}, 1'b1}
                                             : arms_i;
            active_o <= 1'b1;
            prehit_o <= ~pre_on;
          end
        end
        S_PRE: begin
          // Pre-arm readings run on until the arm is taken
          if (trig_evt_i && pre_on) begin
            convert_o <= 1'b1;
            if (!prehit_o) begin
              pre_q <= pre_q + 1'b1;
              prehit_o <= (pre_q + 1'b1 >= prearm_i);
            end
          end
          // An arm before the pre-arm count is ignored
          if (arm_evt_i && prehit_o) begin
            st_q <= S_POST;
            wait_o <= 1'b1;
            left_o <= post_n;
          end
        end
        S_POST: begin
          // Immediate command takes one reading whatever the source
          if (trig_evt_i || imm_i) begin
            convert_o <= 1'b1;
            left_o <= left_o - 1'b1;
            if (left_o == {{(CW-1){1'b0}}, 1'b1}) begin
              wait_o <= 1'b0;
              if (arms_q == {{(AW-1){1'b0}}, 1'b1}) begin
                st_q <= S_IDLE;
                active_o <= 1'b0;
                prehit_o <= 1'b0;
              end else begin
                arms_q <= arms_q - 1'b1;
                st_q <= S_PRE;
                pre_q <= {CW{1'b0}};
                prehit_o <= ~pre_on;
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule

//--- verilog/tsr_top.v
// Trigger and reference sync router with its Wishbone register file
`timescale 1ns/1ps
`include "tsr_regs.vh"

// How it works
// - An immediate command while waiting for triggers takes one reading, counts it, and keeps the source.
// - An ECL line fed by the trigger pulses once per convert pulse.
// - An ECL line fed by the reference rises on external falls, or on rises of ECL or 10 MHz.
// - An ECL line fed by the front output carries that output's signal inverted.
// - The front output fed by the trigger pulses once per convert pulse.
// - The front output fed by the reference falls on external falls, or on rises of ECL or 10 MHz.
// - The front output fed by the pre-arm count rests high and goes low once the count is reached.
// - A TTL line carrying ready is low while initiated and high once readings finish.
// - With post-arm readings only, ready returns high only after arm and trigger counts are both met, or at once on an abort.
// - A pin chosen as reference, arm or trigger input is never driven as an output.
// - Every output except convert_o has its own enable and drives only while enabled.
// - The two ECL lines have their own feed selections.
module tsr_top #(
  parameter CW = 16,
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pin inputs
  input wire ext1_i,
  input wire ext2_i,
  input wire clk10_i,
  input wire [1:0] ecl_i,
  input wire [7:0] ttl_i,
  // Front output and backplane lines
  output reg bnc_o,
  output reg bnc_oe_o,
  output reg [1:0] ecl_o,
  output reg [1:0] ecl_oe_o,
  output reg [7:0] ttl_o,
  output reg [7:0] ttl_oe_o,
  // Convert pulse to the converter
  output reg convert_o
);

  // Byte-lane merge of a write
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Pick one event from a source-indexed vector
  function pick;
    input [15:0] vec;
    input [3:0] code;
    begin
      pick = vec[code];
    end
  endfunction

  // Registers
  reg [31:0] src_q;
  reg [31:0] tmr_q;
  reg [31:0] cnt_q;
  reg [31:0] pre_q;
  reg [31:0] out_q;
  reg start_q;
  reg imm_q;
  reg abort_q;

  wire [3:0] trig_sel = src_q[`TSR_SRC_TRIG_LSB +: 4];
  wire [3:0] arm_sel = src_q[`TSR_SRC_ARM_LSB +: 4];
  wire [2:0] ref_sel = src_q[`TSR_SRC_REF_LSB +: 3];

  // Bus decode; every address answers, unmapped reads return zero
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;

  // Sequencer state
  wire seq_conv;
  wire seq_act;
  wire seq_wait;
  wire seq_hit;
  wire [CW-1:0] seq_left;

  // Synchronised pins: ext1, ext2, ecl[1:0], ttl[7:0], clk10
  wire [12:0] pin_s;
  reg [12:0] pin_p_q;
  // Edges stay masked until both sync stages and the edge flop hold real
  // levels; idle-high TTL lines would otherwise look like a rise at reset
  reg [1:0] settle_q;
  wire pins_live = (settle_q == `TSR_SETTLE_CNT);
  wire [12:0] pin_r = pin_s & ~pin_p_q & {13{pins_live}};

  tsr_sync2 #(
    .W(13)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({clk10_i, ttl_i, ecl_i, ext2_i, ext1_i}),
    .q_o(pin_s)
  );

  // Count edges after reset until the pin path is full
  always @(posedge clk_i) begin
    if (rst_i) begin
      settle_q <= 2'h0;
    end else if (!pins_live) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Register writes and command pulses
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= `TSR_SRC_RST;
      tmr_q <= `TSR_TIMER_RST;
      cnt_q <= `TSR_CNT_RST;
      pre_q <= `TSR_PRE_RST;
      out_q <= `TSR_OUT_RST;
      start_q <= 1'b0;
      imm_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      imm_q <= 1'b0;
      abort_q <= 1'b0;
      if (wr) begin
        case (wb_adr_i)
          `TSR_A_CTRL: begin
            if (wb_sel_i[0]) begin
              start_q <= wb_dat_i[`TSR_CTRL_INIT];
              imm_q <= wb_dat_i[`TSR_CTRL_IMM];
              abort_q <= wb_dat_i[`TSR_CTRL_ABORT];
            end
          end
          `TSR_A_SRC:
            src_q <= wmerge(src_q, wb_dat_i, wb_sel_i) & `TSR_SRC_MASK;
          `TSR_A_TIMER:
            tmr_q <= wmerge(tmr_q, wb_dat_i, wb_sel_i) & `TSR_TIMER_MASK;
          `TSR_A_COUNT:
            cnt_q <= wmerge(cnt_q, wb_dat_i, wb_sel_i) & `TSR_CNT_MASK;
          `TSR_A_PREARM:
            pre_q <= wmerge(pre_q, wb_dat_i, wb_sel_i) & `TSR_PRE_MASK;
          `TSR_A_OUTCFG:
            out_q <= wmerge(out_q, wb_dat_i, wb_sel_i) & `TSR_OUT_MASK;
          default: ;
        endcase
      end
    end
  end

  // Read mux, registered with the single-cycle ack
  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      `TSR_A_SRC: rd = src_q;
      `TSR_A_TIMER: rd = tmr_q;
      `TSR_A_COUNT: rd = cnt_q;
      `TSR_A_PREARM: rd = pre_q;
      `TSR_A_OUTCFG: rd = out_q;
      `TSR_A_STATUS: begin
        rd[`TSR_ST_ACTIVE] = seq_act;
        rd[`TSR_ST_WAIT] = seq_wait;
        rd[`TSR_ST_PREHIT] = seq_hit;
        rd[`TSR_ST_LEFT_LSB +: CW] = seq_left;
      end
      default: rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd : 32'h0000_0000;
    end
  end

  // Reference level; the internal one is a clk/2 square
  reg int_tgl_q;
  reg ref_lvl;
  always @* begin
    case (ref_sel)
      `TSR_REF_CLK10: ref_lvl = pin_s[12];
      `TSR_REF_ECL0: ref_lvl = pin_s[2];
      `TSR_REF_ECL0 + 3'h1: ref_lvl = pin_s[3];
      `TSR_REF_EXT2: ref_lvl = pin_s[1];
      default: ref_lvl = int_tgl_q;
    endcase
  end
  wire ref_ext = (ref_sel != `TSR_REF_INT);
  reg ref_p_q;
  // Internal reference gives a tick on every clock
  wire ref_tick = ref_ext ? (ref_lvl & ~ref_p_q) : 1'b1;

  // Sample timer counts reference ticks
  reg [15:0] tdiv_q;
  reg tick_q;
  wire [15:0] tper = tmr_q[15:0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_tgl_q <= 1'b0;
      ref_p_q <= 1'b0;
      pin_p_q <= 13'h0000;
      tdiv_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      int_tgl_q <= ~int_tgl_q;
      ref_p_q <= ref_lvl;
      pin_p_q <= pin_s;
      tick_q <= 1'b0;
      if (ref_tick) begin
        if (tdiv_q + 16'h0001 >= tper) begin
          tdiv_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          tdiv_q <= tdiv_q + 16'h0001;
        end
      end
    end
  end

  // Event vectors indexed by source code; code 0 is timer or immediate arm
  wire [15:0] trig_vec = {pin_r[11:4], 2'b00, pin_r[3:0], 1'b0, tick_q};
  wire [15:0] arm_vec = {pin_r[11:4], 2'b00, pin_r[3:0], 1'b0, 1'b1};

  tsr_seq #(
    .CW(CW),
    .AW(AW)
  ) u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_q),
    .abort_i(abort_q),
    .imm_i(imm_q),
    .arm_evt_i(pick(arm_vec, arm_sel)),
    .trig_evt_i(pick(trig_vec, trig_sel)),
    .prearm_i(pre_q[CW-1:0]),
    .count_i(cnt_q[`TSR_CNT_TRIG_LSB +: CW]),
    .arms_i(cnt_q[`TSR_CNT_ARM_LSB +: AW]),
    .convert_o(seq_conv),
    .active_o(seq_act),
    .wait_o(seq_wait),
    .prehit_o(seq_hit),
    .left_o(seq_left)
  );

  // Reference as seen on each line type: ECL rises, front falls
  wire ecl_ref = (ref_sel == `TSR_REF_EXT2) ? ~ref_lvl : ref_lvl;
  wire bnc_ref = ~ecl_ref;

  // Front output signal, active-low pulses as TTL edges are falling
  reg bnc_sig;
  wire [1:0] bnc_feed = out_q[`TSR_OUT_BNC_FEED +: 2];
  always @* begin
    case (bnc_feed)
      `TSR_FEED_TRIG: bnc_sig = ~seq_conv;
      `TSR_FEED_REF: bnc_sig = bnc_ref;
      `TSR_FEED_AUX: bnc_sig = ~(seq_act & seq_hit);
      default: bnc_sig = 1'b1;
    endcase
  end

  // Per-line ECL feeds and input conflicts
  reg [1:0] ecl_sig;
  reg [1:0] ecl_blk;
  reg [7:0] ttl_blk;
  integer n;
  always @* begin
    for (n = 0; n < 2; n = n + 1) begin
      case (out_q[`TSR_OUT_ECL_FEED + 2*n +: 2])
        `TSR_FEED_TRIG: ecl_sig[n] = seq_conv;
        `TSR_FEED_REF: ecl_sig[n] = ecl_ref;
        `TSR_FEED_AUX: ecl_sig[n] = ~bnc_sig;
        default: ecl_sig[n] = 1'b0;
      endcase
      ecl_blk[n] = (trig_sel == `TSR_SEL_ECL0 + n[3:0]) |
                   (arm_sel == `TSR_SEL_ECL0 + n[3:0]) |
                   (ref_sel == `TSR_REF_ECL0 + n[2:0]);
    end
    for (n = 0; n < 8; n = n + 1) begin
      ttl_blk[n] = (trig_sel == `TSR_SEL_TTL0 + n[3:0]) |
                   (arm_sel == `TSR_SEL_TTL0 + n[3:0]);
    end
  end
  wire bnc_blk = (trig_sel == `TSR_SEL_EXT1) |
                 (arm_sel == `TSR_SEL_EXT1);

  // Drive only enabled, unblocked outputs; others rest inactive
  wire bnc_drv = out_q[`TSR_OUT_BNC_EN] & ~bnc_blk;
  wire [1:0] ecl_drv = out_q[`TSR_OUT_ECL_EN +: 2] & ~ecl_blk;
  wire [7:0] ttl_drv = out_q[`TSR_OUT_TTL_EN +: 8] & ~ttl_blk;

  // Ready stays low from initiate until the last convert has left the
  // pins, so the final pulse of a burst never meets a high ready line
  wire ready_lo = seq_act | seq_conv;

  // Output flops keep pins glitch-free from the source muxes
  always @(posedge clk_i) begin
    if (rst_i) begin
      bnc_o <= 1'b1;
      bnc_oe_o <= 1'b0;
      ecl_o <= 2'h0;
      ecl_oe_o <= 2'h0;
      convert_o <= 1'b0;
    end else begin
      convert_o <= seq_conv;
      bnc_oe_o <= bnc_drv;
      bnc_o <= bnc_drv ? bnc_sig : 1'b1;
      ecl_oe_o <= ecl_drv;
      ecl_o <= ecl_drv & ecl_sig;
    end
  end

  // TTL lines bit by bit: ready pulls low, released lines rest high
  always @(posedge clk_i) begin
    if (rst_i) begin
      ttl_o <= 8'hff;
      ttl_oe_o <= 8'h00;
    end else begin
      ttl_oe_o <= ttl_drv;
      ttl_o <= ~(ttl_drv & {8{ready_lo}});
    end
  end

endmodule

//--- test/tsr_checker.sv
// Concurrent checks on the sync router's output pins
`timescale 1ns/1ps
module tsr_checker (
  // Clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Outputs
  input wire bnc_o,
  input wire bnc_oe_o,
  input wire [1:0] ecl_o,
  input wire [1:0] ecl_oe_o,
  input wire [7:0] ttl_o,
  input wire [7:0] ttl_oe_o,
  input wire convert_o
);
  reg [31:0] src_q;
  reg [31:0] out_q;
  reg [1:0] age_q;
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // Shadow of routing setup; assumes whole-word writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 32'h0;
      out_q <= 32'h0;
    end else if (wr && wb_adr_i == 8'h04) begin
      src_q <= wb_dat_i;
    end else if (wr && wb_adr_i == 8'h14) begin
      out_q <= wb_dat_i;
    end
  end
  // Settle time after any write, so pipelining never trips a check
  always @(posedge clk_i) begin
    if (rst_i || wr) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  wire steady = age_q == 2'h3;
  wire [3:0] trg = src_q[3:0];
  wire [3:0] arm = src_q[11:8];
  wire [2:0] rf = src_q[18:16];
  // Pins taken as inputs
  wire bnc_blk = trg == 4'h2 || arm == 4'h2;
  wire [1:0] ecl_blk = {trg == 4'h5 || arm == 4'h5 || rf == 3'h3,
    trg == 4'h4 || arm == 4'h4 || rf == 3'h2};
  wire [7:0] ttl_blk = (trg[3] ? 8'h01 << trg[2:0] : 8'h00) |
    (arm[3] ? 8'h01 << arm[2:0] : 8'h00);
  wire bnc_on = out_q[8] & ~bnc_blk;
  wire [1:0] ecl_on = out_q[10:9] & ~ecl_blk;
  wire [7:0] ttl_on = out_q[23:16] & ~ttl_blk;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence conv_rise;
    !convert_o ##1 convert_o;
  endsequence

  AST_BNC_OE: assert property (
    steady |-> bnc_oe_o == bnc_on)
    else $error("front enable wrong");
  AST_ECL_OE: assert property (
    steady |-> ecl_oe_o == ecl_on)
    else $error("ECL enable wrong");
  AST_TTL_OE: assert property (
    steady |-> (ttl_oe_o & ~ttl_on) == 8'h00)
    else $error("TTL driven while off or blocked");
  AST_IDLE_LVL: assert property (
    (ecl_o & ~ecl_oe_o) == 2'b00 && (~ttl_o & ~ttl_oe_o) == 8'h00
    && (bnc_oe_o || bnc_o))
    else $error("undriven pin not at rest level");
  AST_ECL_TRIG: assert property (
    steady && ecl_oe_o[0] && out_q[3:2] == 2'h0 |-> ecl_o[0] == convert_o)
    else $error("ECL trigger pulse mismatch");
  AST_BNC_TRIG: assert property (
    steady && bnc_oe_o && out_q[1:0] == 2'h0 |-> bnc_o == !convert_o)
    else $error("front trigger pulse mismatch");
  AST_ECL_INV: assert property (
    steady && ecl_oe_o[1] && bnc_oe_o && out_q[5:4] == 2'h2
    |-> ecl_o[1] == !bnc_o)
    else $error("ECL copy of front not inverted");
  AST_CONV_PULSE: assert property (
    conv_rise |=> !convert_o ##1 !convert_o)
    else $error("convert pulse too long");
endmodule

bind tsr_top tsr_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .bnc_o(bnc_o), .bnc_oe_o(bnc_oe_o), .ecl_o(ecl_o),
  .ecl_oe_o(ecl_oe_o), .ttl_o(ttl_o), .ttl_oe_o(ttl_oe_o),
  .convert_o(convert_o));

//--- test/tsr_far.sv
// Front pins and backplane lines as driven by other instruments
`timescale 1ns/1ps
module tsr_far (
  // Clock
  input wire clk_i,
  // Levels: 0 ext1, 1 ext2, 2 clk10, 3 ecl0, 4 ttl0
  output reg [4:0] pin_o
);
  // TTL rests high on its pull-up, ECL low on its termination
  initial pin_o = 5'h10;
  // Pins stand still unless a test moves them
  task drive(input int b, input bit v);
    @(posedge clk_i);
    pin_o[b] <= v;
  endtask
  // One edge pair away from rest and back
  task pulse(input int b, input int half);
    drive(b, ~pin_o[b]);
    repeat (half) @(posedge clk_i);
    drive(b, ~pin_o[b]);
    repeat (half) @(posedge clk_i);
  endtask
endmodule

//--- test/tb.sv
// Register-level tests of the sync router
`timescale 1ns/1ps
module tb;
  reg clk_i = 0;
  reg rst_i = 1;
  reg cyc = 0;
  reg we = 0;
  reg [7:0] adr = 0;
  reg [31:0] wdat = 0;
  reg [31:0] rd;
  wire [31:0] dat_o;
  wire ack, bnc_o, bnc_oe_o, convert_o;
  wire [1:0] ecl_o, ecl_oe_o;
  wire [7:0] ttl_o, ttl_oe_o;
  wire [4:0] pin;
  int fail_count = 0;
  int n_tests = 0;
  int cnt [5] = '{0, 0, 0, 0, 0};
  int base [5];
  int ex [5] = '{8, 0, 8, 8, 8};
  int rp [2] = '{2, 1};
  logic [31:0] rc [2] = '{32'h0001_0000, 32'h0004_0000};
  logic [31:0] rv [8] = '{0, 0, 1, 32'h0001_0001, 0, 0, 0, 0};

  tsr_top #(.CW(16), .AW(8)) i_tsr_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext1_i(pin[0]), .ext2_i(pin[1]), .clk10_i(pin[2]),
    .ecl_i((ecl_o & ecl_oe_o) | {1'b0, pin[3]}),
    .ttl_i((ttl_o | ~ttl_oe_o) & {7'h7f, pin[4]}),
    .bnc_o(bnc_o), .bnc_oe_o(bnc_oe_o), .ecl_o(ecl_o),
    .ecl_oe_o(ecl_oe_o), .ttl_o(ttl_o), .ttl_oe_o(ttl_oe_o),
    .convert_o(convert_o));
  tsr_far u_far (.clk_i(clk_i), .pin_o(pin));

  initial forever #25 clk_i = ~clk_i;

  // Pulse tallies: converts, converts while ready high, line pulses
  always @(posedge clk_i) begin
    if (convert_o === 1'b1) cnt[0] <= cnt[0] + 1;
    if (convert_o === 1'b1 && ttl_o[0] !== 1'b0) cnt[1] <= cnt[1] + 1;
    if (ecl_o[0] === 1'b1) cnt[2] <= cnt[2] + 1;
    if (ecl_o[1] === 1'b1) cnt[3] <= cnt[3] + 1;
    if (bnc_o === 1'b0 && bnc_oe_o === 1'b1) cnt[4] <= cnt[4] + 1;
  end

  task chk(input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; waits for ack under a bound
  task automatic wb(input [7:0] a, input w, input [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = dat_o;
    if (t >= 50) fail_count++;
    cyc <= 0;
    we <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(a, 1, d);
  endtask
  task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
    wb(a, 0, 0);
    chk(rd & m, e);
  endtask
  task automatic wait_idle;
    int t;
    t = 0;
    do begin
      wb(8'h18, 0, 0);
      t++;
    end while (rd[0] !== 1'b0 && t < 300);
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    foreach (rv[i]) rdm(8'h04 * i, 32'hffff_ffff, rv[i]);
    chk({bnc_o, bnc_oe_o, ecl_o, ecl_oe_o, ttl_o, ttl_oe_o},
      {4'h8, 2'h0, 16'hff00});
    $display("test reset done");
    // Two arms of four post-arm readings, timer paced
    wr(8'h14, 32'h0001_0720);
    wr(8'h08, 32'h0000_0014);
    wr(8'h0c, 32'h0002_0004);
    base = cnt;
    wr(8'h00, 32'h1);
    repeat (6) @(posedge clk_i);
    chk(ttl_o[0], 0);
    wait_idle;
    repeat (2) @(posedge clk_i);
    foreach (ex[i]) chk(cnt[i] - base[i], ex[i]);
    chk(ttl_o[0], 1);
    $display("test routing done");
    // Held source, readings only by immediate command
    wr(8'h04, 32'h0000_0001);
    wr(8'h0c, 32'h0001_0003);
    wr(8'h00, 32'h1);
    repeat (6) @(posedge clk_i);
    rdm(8'h18, 32'hffff_0003, 32'h0003_0003);
    base = cnt;
    for (int k = 2; k >= 0; k--) begin
      wr(8'h00, 32'h2);
      repeat (6) @(posedge clk_i);
      rdm(8'h18, 32'hffff_0001, {k[15:0], 15'h0, k != 0});
    end
    wr(8'h00, 32'h2);
    repeat (6) @(posedge clk_i);
    chk(cnt[0] - base[0], 3);
    rdm(8'h04, 32'hffff_ffff, 32'h1);
    $display("test immediate done");
    // Pre-arm count of three, TTL0 triggers, Ext2 arms
    wr(8'h04, 32'h0000_0308);
    wr(8'h10, 32'h0000_0003);
    wr(8'h0c, 32'h0001_0005);
    wr(8'h14, 32'h0001_0102);
    wr(8'h00, 32'h1);
    repeat (2) u_far.pulse(4, 4);
    repeat (6) @(posedge clk_i);
    chk({bnc_o, ttl_oe_o[0]}, 2'b10);
    u_far.pulse(4, 4);
    repeat (6) @(posedge clk_i);
    chk(bnc_o, 0);
    u_far.pulse(1, 4);
    repeat (2) u_far.pulse(4, 4);
    wait_idle;
    chk(rd[0], 0);
    $display("test pre-arm done");
    // Reference feed on front and ECL0, two reference kinds
    wr(8'h14, 32'h0000_0705);
    foreach (rp[r]) begin
      wr(8'h04, rc[r]);
      for (int k = 1; k >= 0; k--) begin
        u_far.drive(rp[r], k);
        repeat (8) @(posedge clk_i);
        chk({ecl_o[0], bnc_o}, r ? {~k[0], k[0]} : {k[0], ~k[0]});
      end
    end
    wr(8'h04, 32'h0003_0002);
    repeat (4) @(posedge clk_i);
    chk({ecl_oe_o[1], bnc_oe_o, bnc_o}, 3'b001);
    $display("test reference done");
    summarize;
  end
endmodule
